// ==== rtl/mxe_pkg.sv ====
// Package of constants, opcodes and flag layout for the instruction execution subset
// =====================================================================
// Notes on behaviour
// RQ1 - Set-byte writes all ones to the addressed byte, flags untouched.
// RQ2 - Set-bit forces only the selected bit to one, flags untouched.
// RQ3 - Increment-skip writes byte plus one back, skips when zero, no flags.
// RQ4 - Increment-skip-to-acc puts byte plus one in acc, skips when zero.
// RQ5 - Decrement-skip-to-acc puts byte minus one in acc, skips when zero.
// RQ6 - Conditional skips take one cycle; a taken skip inserts a dummy cycle.
// RQ7 - Skip-if-bit-nonzero skips when selected bit is one, changes nothing.
// RQ8 - Skip-if-bit-zero skips when selected bit is zero, changes nothing.
// RQ9 - Skip-if-byte-zero writes byte back unchanged, skips when zero.
// RQ10 - Skip-if-zero-to-acc copies byte to acc, skips when zero.
// RQ11 - Subtract puts acc minus byte in acc, or in memory for that variant.
// RQ12 - Immediate subtract stores acc minus operand in acc, same flags.
// RQ13 - Subtraction carry is clear on borrow, set when result non-negative.
// RQ14 - Subtraction updates overflow, zero, nibble carry and carry flags.
// RQ15 - Nibble exchange swaps the two nibbles of the byte in place.
// RQ16 - Nibble-exchange-to-acc writes swapped byte to acc, memory unchanged.
// RQ17 - Paged table read uses high and low pointers; low to memory, high to latch.
// RQ18 - Last-page table read uses last page and low pointer likewise.
// RQ19 - XOR with memory byte stores in acc, updates only zero flag.
// RQ20 - XOR into memory writes result to the byte, updates only zero flag.
// RQ21 - Immediate XOR stores in acc, updates only zero flag.
// RQ22 - A skipped instruction changes no memory, acc, flag or table latch.
package mxe_pkg;

  // =====================================================================
  // Operation codes given by the sequencer's decoder
  typedef enum logic [4:0] {
    MXE_OP_NOP       = 5'h00,
    MXE_OP_SET_BYTE  = 5'h01,
    MXE_OP_SET_BIT   = 5'h02,
    MXE_OP_INC_SKIP  = 5'h03,
    MXE_OP_INCA_SKIP = 5'h04,
    MXE_OP_DECA_SKIP = 5'h05,
    MXE_OP_SKIP_BNZ  = 5'h06,
    MXE_OP_SKIP_BZ   = 5'h07,
    MXE_OP_SKIP_Z    = 5'h08,
    MXE_OP_SKIPA_Z   = 5'h09,
    MXE_OP_SUB_ACC   = 5'h0a,
    MXE_OP_SUB_MEM   = 5'h0b,
    MXE_OP_SUB_IMM   = 5'h0c,
    MXE_OP_SWAP      = 5'h0d,
    MXE_OP_NIBBLE_EXCHANGE_TO_ACC     = 5'h0e,
    MXE_OP_TAB_PAGED = 5'h0f,
    MXE_OP_TAB_LAST  = 5'h10,
    MXE_OP_XOR_ACC   = 5'h11,
    MXE_OP_XOR_MEM   = 5'h12,
    MXE_OP_XOR_IMM   = 5'h13
  } mxe_op_t;

  // =====================================================================
  // Execution states, Gray coded along run then dummy
  typedef enum logic [1:0] {
    MXE_ST_RUN   = 2'b00,
    MXE_ST_DUMMY = 2'b01
  } mxe_state_t;

  // Flag bit positions in the flag vector
  localparam int MXE_FLAG_C  = 0;
  localparam int MXE_FLAG_AC = 1;
  localparam int MXE_FLAG_Z  = 2;
  localparam int MXE_FLAG_OV = 3;

  // Values after reset and constants
  localparam logic [7:0] MXE_ACC_RST   = 8'h00;
  localparam logic [3:0] MXE_FLAGS_RST = 4'h0;
  localparam logic [7:0] MXE_TABLE_READ_HIGH_LATCH_RST  = 8'h00;
  localparam logic [7:0] MXE_ALL_ONES  = 8'hff;

endpackage : mxe_pkg

// ==== rtl/mxe_exec.sv ====
// Execution unit for a subset of an 8-bit microcontroller instruction set
`timescale 1ns/10ps
module mxe_exec
  import mxe_pkg::*;
#(
  parameter int PROG_AW = 12
) (
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               sys_rst_i,
  // Instruction from the sequencer, one per cycle
  input  wire logic               instr_valid_i,
  input  wire mxe_op_t            instr_op_i,
  input  wire logic [2:0]         instr_bit_i,
  input  wire logic [7:0]         instr_imm_i,
  // Data memory read value of the addressed byte
  input  wire logic [7:0]         mem_rdata_i,
  // Table pointers
  input  wire logic [7:0]         table_pointer_low_byte_i,
  input  wire logic [7:0]         table_pointer_high_byte_i,
  input  wire logic               has_high_pointer_i,
  // Program memory word for the table pointer address
  input  wire logic [15:0]        prog_word_i,
  // Data memory write
  output logic                    mem_we_o,
  output logic [7:0]              mem_wdata_o,
  // Program memory table address, combinational
  output logic [PROG_AW-1:0]      prog_addr_o,
  // Sequencer control
  output logic                    skip_o,
  output logic                    busy_o,
  // Core state
  output logic [7:0]              acc_o,
  output logic [3:0]              flags_o,
  output logic [7:0]              table_read_high_latch_o
);

  // =====================================================================
  // State and registers
  mxe_state_t state_r;
  mxe_state_t state_nxt;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic [7:0] table_read_high_latch_r;
  logic [7:0] table_read_high_latch_nxt;
  logic       mem_we_nxt;
  logic [7:0] mem_wdata_nxt;
  logic       skip_nxt;
  logic       mem_we_r;
  logic [7:0] mem_wdata_r;
  logic       skip_r;

  // Shared arithmetic
  logic       exec;
  logic [7:0] inc_v;
  logic [7:0] dec_v;
  logic [7:0] swap_v;
  logic [7:0] sub_b;
  logic [8:0] sub_full;
  logic [4:0] sub_low;
  logic [7:0] sub_v;
  logic [3:0] sub_flags;
  logic       sel_bit;

  // Instructions arriving during the dummy cycle are the skipped ones
  assign exec     = instr_valid_i && (state_r == MXE_ST_RUN); // RQ22
  assign inc_v    = mem_rdata_i + 8'h01;
  assign dec_v    = mem_rdata_i - 8'h01;
  assign swap_v   = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
  assign sel_bit  = mem_rdata_i[instr_bit_i];
  assign sub_b    = (instr_op_i == MXE_OP_SUB_IMM) ? instr_imm_i : mem_rdata_i; // RQ12
  assign sub_full = {1'b0, acc_r} - {1'b0, sub_b};
  assign sub_low  = {1'b0, acc_r[3:0]} - {1'b0, sub_b[3:0]};
  assign sub_v    = sub_full[7:0];

  // Subtraction flags; carry is the inverted borrow
  always_comb begin
    sub_flags              = '0;
    sub_flags[MXE_FLAG_C]  = ~sub_full[8]; // RQ13
    sub_flags[MXE_FLAG_AC] = ~sub_low[4]; // RQ14
    sub_flags[MXE_FLAG_Z]  = (sub_v == 8'h00); // RQ14
    sub_flags[MXE_FLAG_OV] = (acc_r[7] ^ sub_b[7]) & (acc_r[7] ^ sub_v[7]); // RQ14
  end

  // Table address: last page is all ones above the low pointer
  always_comb begin
    if (instr_op_i == MXE_OP_TAB_LAST) begin
      prog_addr_o = {{(PROG_AW-8){1'b1}}, table_pointer_low_byte_i}; // RQ18
    end else if (has_high_pointer_i) begin
      prog_addr_o = PROG_AW'({table_pointer_high_byte_i, table_pointer_low_byte_i}); // RQ17
    end else begin
      prog_addr_o = PROG_AW'(table_pointer_low_byte_i); // RQ17
    end
  end

  // Next-value decode
  always_comb begin
    acc_nxt       = acc_r;
    flags_nxt     = flags_r;
    table_read_high_latch_nxt      = table_read_high_latch_r;
    mem_we_nxt    = 1'b0;
    mem_wdata_nxt = mem_wdata_r;
    skip_nxt      = 1'b0;
    state_nxt     = MXE_ST_RUN;
    if (exec) begin
      case (instr_op_i)
        MXE_OP_SET_BYTE: begin
          mem_we_nxt    = 1'b1;
          mem_wdata_nxt = MXE_ALL_ONES; // RQ1
        end
        MXE_OP_SET_BIT: begin
          mem_we_nxt    = 1'b1;
          mem_wdata_nxt = mem_rdata_i | (8'h01 << instr_bit_i); // RQ2
        end
        MXE_OP_INC_SKIP: begin
          mem_we_nxt    = 1'b1;
          mem_wdata_nxt = inc_v; // RQ3
          skip_nxt      = (inc_v == 8'h00);
        end
        MXE_OP_INCA_SKIP: begin
          acc_nxt  = inc_v; // RQ4
          skip_nxt = (inc_v == 8'h00);
        end
        MXE_OP_DECA_SKIP: begin
          acc_nxt  = dec_v; // RQ5
          skip_nxt = (dec_v == 8'h00);
        end
        MXE_OP_SKIP_BNZ: begin
          skip_nxt = sel_bit; // RQ7
        end
        MXE_OP_SKIP_BZ: begin
          skip_nxt = ~sel_bit; // RQ8
        end
        MXE_OP_SKIP_Z: begin
          mem_we_nxt    = 1'b1;
          mem_wdata_nxt = mem_rdata_i; // RQ9
          skip_nxt      = (mem_rdata_i == 8'h00);
        end
        MXE_OP_SKIPA_Z: begin
          acc_nxt  = mem_rdata_i; // RQ10
          skip_nxt = (mem_rdata_i == 8'h00);
        end
        MXE_OP_SUB_ACC, MXE_OP_SUB_IMM: begin
          acc_nxt   = sub_v; // RQ11 RQ12
          flags_nxt = sub_flags;
        end
        MXE_OP_SUB_MEM: begin
          mem_we_nxt    = 1'b1;
          mem_wdata_nxt = sub_v; // RQ11
          flags_nxt     = sub_flags;
        end
        MXE_OP_SWAP: begin
          mem_we_nxt    = 1'b1;
          mem_wdata_nxt = swap_v; // RQ15
        end
        MXE_OP_NIBBLE_EXCHANGE_TO_ACC: begin
          acc_nxt = swap_v; // RQ16
        end
        MXE_OP_TAB_PAGED, MXE_OP_TAB_LAST: begin
          mem_we_nxt    = 1'b1;
          mem_wdata_nxt = prog_word_i[7:0]; // RQ17 RQ18
          table_read_high_latch_nxt      = prog_word_i[15:8];
        end
        MXE_OP_XOR_ACC, MXE_OP_XOR_IMM, MXE_OP_XOR_MEM: begin
          // Only zero flag moves; other flags hold
          if (instr_op_i == MXE_OP_XOR_MEM) begin
            mem_we_nxt    = 1'b1;
            mem_wdata_nxt = acc_r ^ mem_rdata_i; // RQ20
            flags_nxt[MXE_FLAG_Z] = ((acc_r ^ mem_rdata_i) == 8'h00);
          end else begin
            acc_nxt = acc_r ^ ((instr_op_i == MXE_OP_XOR_IMM) ? instr_imm_i
                                                                : mem_rdata_i); // RQ19 RQ21
            flags_nxt[MXE_FLAG_Z] = (acc_nxt == 8'h00);
          end
        end
        default: begin
          acc_nxt = acc_r;
        end
      endcase
      if (skip_nxt) begin
        state_nxt = MXE_ST_DUMMY; // RQ6
      end
    end
  end

  // State machine: one dummy cycle after a taken skip
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_r <= MXE_ST_RUN;
    end else begin
      state_r <= state_nxt; // RQ6
    end
  end

  // Accumulator, flags and table latch
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      acc_r   <= MXE_ACC_RST;
      flags_r <= MXE_FLAGS_RST;
      table_read_high_latch_r  <= MXE_TABLE_READ_HIGH_LATCH_RST;
    end else begin
      acc_r   <= acc_nxt;
      flags_r <= flags_nxt;
      table_read_high_latch_r  <= table_read_high_latch_nxt;
    end
  end

  // Registered memory write and skip pulse
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mem_we_r    <= 1'b0;
      mem_wdata_r <= 8'h00;
      skip_r      <= 1'b0;
    end else begin
      mem_we_r    <= mem_we_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      skip_r      <= skip_nxt;
    end
  end

  assign mem_we_o                = mem_we_r;
  assign mem_wdata_o             = mem_wdata_r;
  assign skip_o                  = skip_r;
  assign busy_o                  = (state_r == MXE_ST_DUMMY);
  assign acc_o                   = acc_r;
  assign flags_o                 = flags_r;
  assign table_read_high_latch_o = table_read_high_latch_r;

  // =====================================================================
  // Assertions
  a_skip_dummy_cycle: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ6
    skip_o |-> busy_o)
    else $error("Taken skip without dummy cycle");
  a_dummy_one_cycle: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ6
    busy_o |=> !busy_o)
    else $error("Dummy cycle longer than one");
  a_skipped_no_acc: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ22
    busy_o |=> (acc_o == $past(acc_o)) && (flags_o == $past(flags_o)))
    else $error("Skipped instruction changed acc or flags");
  a_skipped_no_write: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ22
    busy_o |=> !mem_we_o)
    else $error("Skipped instruction wrote memory");
  // A skipped table read could otherwise leak into the latch
  a_skipped_no_latch: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ22
    busy_o |=> table_read_high_latch_o == $past(table_read_high_latch_o))
    else $error("Skipped instruction changed table latch");
  a_set_byte_ones: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ1
    exec && instr_op_i == MXE_OP_SET_BYTE |=> mem_we_o && mem_wdata_o == 8'hff
      && $stable(flags_o))
    else $error("Set byte wrong");
  // Neighbour bits are held against the read value, so a stray write shows
  a_set_bit_only: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ2
    exec && instr_op_i == MXE_OP_SET_BIT |=> mem_we_o && mem_wdata_o[$past(instr_bit_i)]
      && ((mem_wdata_o ^ $past(mem_rdata_i)) & ~(8'h01 << $past(instr_bit_i))) == 8'h00)
    else $error("Set bit wrong");
  a_inc_skip_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ3
    exec && instr_op_i == MXE_OP_INC_SKIP |=> mem_we_o
      && skip_o == (mem_wdata_o == 8'h00))
    else $error("Increment skip wrong");
  a_deca_skip_acc: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ5
    exec && instr_op_i == MXE_OP_DECA_SKIP |=> !mem_we_o && skip_o == (acc_o == 8'h00))
    else $error("Decrement skip to acc wrong");
  // Polarity of both bit skips is folded into one check
  a_bit_skip_sense: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ7 RQ8
    exec && (instr_op_i == MXE_OP_SKIP_BNZ || instr_op_i == MXE_OP_SKIP_BZ) |=> !mem_we_o
      && skip_o == ($past(mem_rdata_i[instr_bit_i]) ^ $past(instr_op_i == MXE_OP_SKIP_BZ)))
    else $error("Bit skip wrong");
  a_sub_carry_sense: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ13
    exec && instr_op_i == MXE_OP_SUB_ACC |=>
      flags_o[MXE_FLAG_C] == ($past(acc_o) >= $past(mem_rdata_i)))
    else $error("Subtract carry wrong");
  a_xor_zero_only: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ19
    exec && instr_op_i == MXE_OP_XOR_ACC |=> flags_o[MXE_FLAG_C] == $past(flags_o[MXE_FLAG_C])
      && flags_o[MXE_FLAG_Z] == (acc_o == 8'h00))
    else $error("XOR flags wrong");
  a_swap_mem: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ15
    exec && instr_op_i == MXE_OP_SWAP |=>
      mem_wdata_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])})
    else $error("Nibble exchange wrong");
  a_nibble_exchange_to_acc_acc: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ16
    exec && instr_op_i == MXE_OP_NIBBLE_EXCHANGE_TO_ACC |=> !mem_we_o
      && acc_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])})
    else $error("Nibble exchange to acc wrong");
  // Low byte to memory and high byte to latch must land on the same edge
  a_table_pair: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ17 RQ18
    exec && (instr_op_i == MXE_OP_TAB_PAGED || instr_op_i == MXE_OP_TAB_LAST) |=> mem_we_o
      && mem_wdata_o == $past(prog_word_i[7:0])
      && table_read_high_latch_o == $past(prog_word_i[15:8]))
    else $error("Table read pairing wrong");
  a_last_page_addr: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ18
    instr_op_i == MXE_OP_TAB_LAST |-> prog_addr_o[7:0] == table_pointer_low_byte_i
      && &prog_addr_o[PROG_AW-1:8])
    else $error("Last page address wrong");

  c_skip_taken: cover property (@(posedge clock_i) skip_o);
  c_sub_borrow: cover property (@(posedge clock_i)
    exec && instr_op_i == MXE_OP_SUB_MEM ##1 !flags_o[MXE_FLAG_C]);
  c_table_read: cover property (@(posedge clock_i) exec && instr_op_i == MXE_OP_TAB_LAST);
  c_dummy_offer: cover property (@(posedge clock_i) busy_o && instr_valid_i);
  c_xor_zero: cover property (@(posedge clock_i)
    exec && instr_op_i == MXE_OP_XOR_ACC ##1 flags_o[MXE_FLAG_Z]);

endmodule : mxe_exec

// ==== bench/mxe_side_model.sv ====
// Model of the data memory byte and program memory facing the execution unit
`timescale 1ns/10ps
module mxe_side_model #(
  parameter int PROG_AW = 12
) (
  // Clock
  input  wire logic               clock_i,
  // Data memory side
  input  wire logic               mem_we_i,
  input  wire logic [7:0]         mem_wdata_i,
  output logic      [7:0]         mem_rdata_o,
  // Program memory side
  input  wire logic [PROG_AW-1:0] prog_addr_i,
  output logic      [15:0]        prog_word_o
);
  logic [7:0] mem_r;

  // =====================================================================
  // Addressed byte; the bench loads it at a falling edge before each op
  task automatic load(input logic [7:0] v);
    mem_r = v;
  endtask : load

  // Write port takes the unit's registered pulse
  always @(posedge clock_i) begin
    if (mem_we_i) mem_r <= mem_wdata_i;
  end

  assign mem_rdata_o = mem_r;
  // Word carries its own address, so a wrong page shows in the high byte
  assign prog_word_o = {4'ha, 12'(prog_addr_i)};
endmodule : mxe_side_model

// ==== bench/tb_mxe_exec.sv ====
// Self-checking testbench for the instruction execution subset
`timescale 1ns/10ps
module tb_mxe_exec;
  import mxe_pkg::*;
  // =====================================================================
  // Signals and bench state
  logic        clock_i, sys_rst_i, instr_valid_i, has_high_pointer_i;
  mxe_op_t     instr_op_i;
  logic [2:0]  instr_bit_i;
  logic [7:0]  instr_imm_i, mem_rdata_i, tp_lo, tp_hi;
  logic [15:0] prog_word_i;
  logic        mem_we_o, skip_o, busy_o;
  logic [7:0]  mem_wdata_o, acc_o, table_read_high_latch_o, e_acc, e_lat;
  logic [11:0] prog_addr_o;
  logic [3:0]  flags_o, e_fl;
  int          error_cnt = 0;
  int          cmp_count = 0;

  mxe_exec #(.PROG_AW(12)) mxe_exec_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .instr_bit_i(instr_bit_i),
    .instr_imm_i(instr_imm_i), .mem_rdata_i(mem_rdata_i),
    .table_pointer_low_byte_i(tp_lo), .table_pointer_high_byte_i(tp_hi),
    .has_high_pointer_i(has_high_pointer_i), .prog_word_i(prog_word_i),
    .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .prog_addr_o(prog_addr_o),
    .skip_o(skip_o), .busy_o(busy_o), .acc_o(acc_o), .flags_o(flags_o),
    .table_read_high_latch_o(table_read_high_latch_o));
  mxe_side_model #(.PROG_AW(12)) mxe_side_model_i (.clock_i(clock_i),
    .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
    .prog_addr_i(prog_addr_o), .prog_word_o(prog_word_i));

  // =====================================================================
  // Clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // One instruction; a taken skip gets a table read offered in its dummy cycle,
  // which must leave no trace. An idle cycle follows so memory writes settle.
  task automatic do_op(input mxe_op_t op, input logic [2:0] bt, input logic [7:0] imm,
                       input logic [7:0] mv, input logic we, input logic [7:0] wd,
                       input logic sk);
    mxe_side_model_i.load(mv);
    instr_op_i = op;
    instr_bit_i = bt;
    instr_imm_i = imm;
    instr_valid_i = 1'b1;
    @(negedge clock_i);
    if (sk) instr_op_i = MXE_OP_TAB_LAST;
    else instr_valid_i = 1'b0;
    chk(mem_we_o, we);
    if (we) chk(mem_wdata_o, wd);
    chk(skip_o, sk);
    chk(busy_o, sk);
    chk(acc_o, e_acc);
    chk(flags_o, e_fl);
    chk(table_read_high_latch_o, e_lat);
    if (sk) begin
      @(negedge clock_i);
      instr_valid_i = 1'b0;
      chk(mem_we_o, 1'b0);
      chk(busy_o, 1'b0);
      chk(acc_o, e_acc);
      chk(flags_o, e_fl);
      chk(table_read_high_latch_o, e_lat);
    end
    @(negedge clock_i);
  endtask : do_op

  // Accumulator loaded by copy, which leaves the flags alone
  task automatic setacc(input logic [7:0] v);
    e_acc = v;
    do_op(MXE_OP_SKIPA_Z, 3'h0, 8'h00, v, 1'b0, 8'h00, v == 8'h00);
  endtask : setacc

  task automatic t_set_skip;
    do_op(MXE_OP_SET_BYTE, 3'h0, 8'h00, 8'h12, 1'b1, MXE_ALL_ONES, 1'b0);
    for (int i = 0; i < 8; i++) begin
      do_op(MXE_OP_SET_BIT, 3'(i), 8'h00, 8'h00, 1'b1, 8'h01 << i, 1'b0);
    end
    do_op(MXE_OP_INC_SKIP, 3'h0, 8'h00, 8'hff, 1'b1, 8'h00, 1'b1);
    do_op(MXE_OP_INC_SKIP, 3'h0, 8'h00, 8'h7f, 1'b1, 8'h80, 1'b0);
    e_acc = 8'h00;
    do_op(MXE_OP_INCA_SKIP, 3'h0, 8'h00, 8'hff, 1'b0, 8'h00, 1'b1);
    do_op(MXE_OP_DECA_SKIP, 3'h0, 8'h00, 8'h01, 1'b0, 8'h00, 1'b1);
    e_acc = 8'hff;
    do_op(MXE_OP_DECA_SKIP, 3'h0, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
    do_op(MXE_OP_SKIP_BNZ, 3'h3, 8'h00, 8'h08, 1'b0, 8'h00, 1'b1);
    do_op(MXE_OP_SKIP_BNZ, 3'h3, 8'h00, 8'hf7, 1'b0, 8'h00, 1'b0);
    do_op(MXE_OP_SKIP_BZ, 3'h3, 8'h00, 8'hf7, 1'b0, 8'h00, 1'b1);
    do_op(MXE_OP_SKIP_BZ, 3'h3, 8'h00, 8'h08, 1'b0, 8'h00, 1'b0);
    do_op(MXE_OP_SKIP_Z, 3'h0, 8'h00, 8'h00, 1'b1, 8'h00, 1'b1);
    do_op(MXE_OP_SKIP_Z, 3'h0, 8'h00, 8'h5a, 1'b1, 8'h5a, 1'b0);
    setacc(8'h00);
    setacc(8'h3c);
    $display("test set and skip done");
  endtask : t_set_skip

  // Cases cover signed overflow, zero, nibble borrow and a negative result
  task automatic t_sub;
    logic [7:0] a[4] = '{8'h80, 8'h05, 8'h10, 8'h01};
    logic [7:0] b[4] = '{8'h01, 8'h05, 8'h01, 8'h02};
    logic [7:0] r;
    int i;
    for (int k = 0; k < 12; k++) begin
      i = k % 4;
      setacc(a[i]);
      r = a[i] - b[i];
      e_fl = {(a[i][7] ^ b[i][7]) & (r[7] ^ a[i][7]), r == 8'h00,
              a[i][3:0] >= b[i][3:0], a[i] >= b[i]};
      case (k / 4)
        0: begin
          e_acc = r;
          do_op(MXE_OP_SUB_ACC, 3'h0, 8'h00, b[i], 1'b0, 8'h00, 1'b0);
        end
        1: do_op(MXE_OP_SUB_MEM, 3'h0, 8'h00, b[i], 1'b1, r, 1'b0);
        default: begin
          e_acc = r;
          do_op(MXE_OP_SUB_IMM, 3'h0, b[i], ~b[i], 1'b0, 8'h00, 1'b0);
        end
      endcase
    end
    $display("test subtract done");
  endtask : t_sub

  task automatic t_swap_tab_xor;
    do_op(MXE_OP_SWAP, 3'h0, 8'h00, 8'h3c, 1'b1, 8'hc3, 1'b0);
    e_acc = 8'h5a;
    do_op(MXE_OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 8'h00, 8'ha5, 1'b0, 8'h00, 1'b0);
    tp_lo = 8'h34;
    tp_hi = 8'h05;
    has_high_pointer_i = 1'b1;
    e_lat = 8'ha5;
    do_op(MXE_OP_TAB_PAGED, 3'h0, 8'h00, 8'h00, 1'b1, 8'h34, 1'b0);
    chk(prog_addr_o, 12'h534);
    e_lat = 8'haf;
    do_op(MXE_OP_TAB_LAST, 3'h0, 8'h00, 8'h00, 1'b1, 8'h34, 1'b0);
    chk(prog_addr_o, 12'hf34);
    has_high_pointer_i = 1'b0;
    e_lat = 8'ha0;
    do_op(MXE_OP_TAB_PAGED, 3'h0, 8'h00, 8'h00, 1'b1, 8'h34, 1'b0);
    chk(prog_addr_o, 12'h034);
    setacc(8'h0f);
    e_acc = 8'h00;
    e_fl[MXE_FLAG_Z] = 1'b1;
    do_op(MXE_OP_XOR_ACC, 3'h0, 8'h00, 8'h0f, 1'b0, 8'h00, 1'b0);
    e_fl[MXE_FLAG_Z] = 1'b0;
    do_op(MXE_OP_XOR_MEM, 3'h0, 8'h00, 8'hf0, 1'b1, 8'hf0, 1'b0);
    e_acc = 8'h5a;
    do_op(MXE_OP_XOR_IMM, 3'h0, 8'h5a, 8'hff, 1'b0, 8'h00, 1'b0);
    $display("test swap table xor done");
  endtask : t_swap_tab_xor

  // =====================================================================
  // Main sequence
  initial begin
    {sys_rst_i, instr_valid_i, has_high_pointer_i} = 3'b100;
    instr_op_i = MXE_OP_NOP;
    {instr_bit_i, instr_imm_i, tp_lo, tp_hi} = '0;
    {e_acc, e_lat, e_fl} = '0;
    repeat (5) @(negedge clock_i);
    sys_rst_i = 1'b0;
    chk({acc_o, table_read_high_latch_o}, {MXE_ACC_RST, MXE_TABLE_READ_HIGH_LATCH_RST});
    chk({flags_o, mem_we_o, busy_o, skip_o}, {MXE_FLAGS_RST, 3'b000});
    t_set_skip();
    t_sub();
    t_swap_tab_xor();
    final_report();
  end

  // Watchdog: tests need about 120 cycles, so this is ample
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
endmodule : tb_mxe_exec
